/* rx_frame_fifo.sv */
// shared constants of the frame memory layout, and the payload fifo
`timescale 1ns/100ps
package rx_frame_pkg;
    localparam int PKT_BYTES = 36;
    localparam int DATA_PKTS = 190;
    localparam int PARITY_PKTS = 82;
    localparam int FIRST_PARITY_PKT = DATA_PKTS;
    localparam int LAST_PARITY_PKT = DATA_PKTS + PARITY_PKTS - 1;
    localparam int RESULT_PKT = DATA_PKTS + PARITY_PKTS;
    localparam int TOTAL_PKTS = RESULT_PKT + 1;
    localparam int MEM_WORDS = TOTAL_PKTS * PKT_BYTES;
    localparam int PKT_W = 9;
    localparam int BYTE_W = 6;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 32;
    // byte positions inside a packet
    localparam logic [5:0] STATUS0_BYTE = 6'h00;
    localparam logic [5:0] STATUS1_BYTE = 6'h01;
    localparam logic [5:0] PAYLOAD_FIRST = 6'h02;
    localparam logic [5:0] LAST_BYTE = 6'h23;
    // status byte 0 field positions
    localparam int S0_CRC1 = 7;
    localparam int S0_ERC1 = 6;
    localparam int S0_RAWCRC = 5;
    localparam int S0_FRAME = 4;
    localparam int S0_BLOCK = 3;
    localparam int S0_CODE_FOUND = 2;
    localparam int S0_CODE_HI = 1;
    localparam int S0_CODE_LO = 0;
    // status byte 1 field positions
    localparam int S1_TRAFFIC = 7;
    localparam int S1_PARITY = 6;
    localparam int S1_EARLY = 5;
    localparam int S1_SECOND_PASS_CRC_ERROR = 4;
    localparam int S1_SECOND_PASS_CORRECTION_ERROR = 3;
    localparam int S1_FRAME_NUMBER_CHANGE = 2;
    localparam int S1_RANGE_HI = 1;
    localparam int S1_RANGE_LO = 0;
    // reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [8:0] PKT_RESET = 9'h000;
endpackage

module rx_frame_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic push;
    logic pop;

    // flags follow the registered count, so in_ready and out_valid are both flop outputs
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data = mem_q[rp_q];

    // storage, no reset needed
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    // pointers and flags
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            wp_q <= push ? AW'(wp_q + 1'b1) : wp_q;
            rp_q <= pop ? AW'(rp_q + 1'b1) : rp_q;
            cnt_q <= cnt_d;
            in_ready <= (cnt_d != (AW+1)'(DEPTH));
            out_valid <= (cnt_d != '0);
        end
    end
endmodule

/* rx_frame_store.sv */
// receive frame memory after the second correction pass, with status bytes
`timescale 1ns/100ps

module rx_frame_store #(
    parameter int FIFO_DEPTH = rx_frame_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // frame control
    input wire logic frame_start,
    input wire logic test_parity_correct,
    // packet header, taken when hdr_valid and hdr_ready while frame_start is low
    input wire logic hdr_valid,
    output logic hdr_ready,
    input wire logic first_pass_crc_error,
    input wire logic first_pass_correction_error,
    input wire logic raw_crc_error,
    input wire logic frame_locked,
    input wire logic block_locked,
    input wire logic block_code_found,
    input wire logic block_code_index_hi,
    input wire logic block_code_index_lo,
    input wire logic traffic_packet_flag,
    input wire logic early_interrupt_packet,
    input wire logic second_pass_crc_error,
    input wire logic second_pass_correction_error,
    input wire logic frame_number_change,
    input wire logic frame_range_hi,
    input wire logic frame_range_lo,
    // payload byte stream, 34 bytes per packet
    input wire logic pay_valid,
    output logic pay_ready,
    input wire logic [7:0] pay_data,
    // position and last packet state
    output logic [8:0] packet_number_reg_a,
    output logic [5:0] packet_number_reg_b,
    output logic writing,
    output logic packet_good,
    // host read port
    input wire logic rd_req,
    input wire logic [8:0] rd_packet,
    input wire logic [5:0] rd_byte,
    output logic rd_valid,
    output logic rd_refused,
    output logic [7:0] rd_data
);
    typedef enum logic [1:0] {S_IDLE, S_ST0, S_ST1, S_PAY} wr_state_e;

    logic [7:0] frame_mem_q [rx_frame_pkg::MEM_WORDS];
    wr_state_e state_q;
    wr_state_e state_d;
    logic [8:0] pkt_q;
    logic [5:0] byte_q;
    logic [7:0] st0_q;
    logic [7:0] st1_q;
    logic fifo_valid;
    logic fifo_pop;
    logic [7:0] fifo_data;
    logic hdr_take;
    logic is_parity;
    logic is_result;
    logic second_pass_on;
    logic [7:0] st0_d;
    logic [7:0] st1_d;
    logic wr_en;
    logic [7:0] wr_data;
    logic pkt_done;
    logic rd_in_range;
    logic rd_blocked;
    logic rd_ok;

    // byte address of a packet/byte pair
    function automatic logic [13:0] addr_of(input logic [8:0] p, input logic [5:0] b);
        addr_of = 14'(p * rx_frame_pkg::PKT_BYTES) + 14'(b);
    endfunction

    // payload buffer between the upstream stream and the memory writer
    rx_frame_fifo #(
        .WIDTH(rx_frame_pkg::DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_valid(pay_valid),
        .in_ready(pay_ready),
        .in_data(pay_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // packet class decode
    assign is_parity = (pkt_q >= 9'(rx_frame_pkg::FIRST_PARITY_PKT))
        && (pkt_q <= 9'(rx_frame_pkg::LAST_PARITY_PKT));
    assign is_result = (pkt_q == 9'(rx_frame_pkg::RESULT_PKT));
    assign second_pass_on = !is_parity || test_parity_correct;
    assign hdr_take = hdr_valid && hdr_ready && !frame_start;

    // status byte 0 is the first-pass header byte
    always_comb begin
        st0_d = 8'h00;
        st0_d[rx_frame_pkg::S0_CRC1] = first_pass_crc_error;
        st0_d[rx_frame_pkg::S0_ERC1] = first_pass_correction_error;
        st0_d[rx_frame_pkg::S0_RAWCRC] = raw_crc_error;
        st0_d[rx_frame_pkg::S0_FRAME] = frame_locked;
        st0_d[rx_frame_pkg::S0_BLOCK] = block_locked;
        st0_d[rx_frame_pkg::S0_CODE_FOUND] = block_code_found;
        st0_d[rx_frame_pkg::S0_CODE_HI] = block_code_index_hi;
        st0_d[rx_frame_pkg::S0_CODE_LO] = block_code_index_lo;
    end

    // status byte 1; second-pass errors only when that pass ran
    always_comb begin
        st1_d = 8'h00;
        st1_d[rx_frame_pkg::S1_TRAFFIC] = traffic_packet_flag;
        st1_d[rx_frame_pkg::S1_PARITY] = is_parity && frame_locked;
        st1_d[rx_frame_pkg::S1_EARLY] = early_interrupt_packet;
        st1_d[rx_frame_pkg::S1_SECOND_PASS_CRC_ERROR] = second_pass_on && second_pass_crc_error;
        st1_d[rx_frame_pkg::S1_SECOND_PASS_CORRECTION_ERROR] = second_pass_on && second_pass_correction_error;
        st1_d[rx_frame_pkg::S1_FRAME_NUMBER_CHANGE] = frame_locked && frame_number_change;
        st1_d[rx_frame_pkg::S1_RANGE_HI] = frame_locked && frame_range_hi;
        st1_d[rx_frame_pkg::S1_RANGE_LO] = frame_locked && frame_range_lo;
    end

    // writer: two status bytes (none in the result packet), then payload bytes 2..35
    assign fifo_pop = (state_q == S_PAY) && !frame_start;
    assign pkt_done = fifo_pop && fifo_valid && (byte_q == rx_frame_pkg::LAST_BYTE);
    assign wr_en = ((state_q == S_ST0) || (state_q == S_ST1)
        || (fifo_pop && fifo_valid)) && !frame_start;
    assign wr_data = (state_q == S_ST0) ? st0_q :
        (state_q == S_ST1) ? st1_q : fifo_data;

    // writer sequence
    always_comb begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (hdr_take) begin
                    state_d = is_result ? S_PAY : S_ST0;
                end
            end
            S_ST0: state_d = S_ST1;
            S_ST1: state_d = S_PAY;
            S_PAY: begin
                if (pkt_done) begin
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
        if (frame_start) begin
            state_d = S_IDLE;
        end
    end

    // frame memory write port
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            frame_mem_q[addr_of(pkt_q, byte_q)] <= wr_data;
        end
    end

    // writer position and status capture
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= S_IDLE;
            pkt_q <= rx_frame_pkg::PKT_RESET;
            byte_q <= rx_frame_pkg::STATUS0_BYTE;
            st0_q <= rx_frame_pkg::BYTE_RESET;
            st1_q <= rx_frame_pkg::BYTE_RESET;
        end else begin
            state_q <= state_d;
            if (frame_start) begin
                pkt_q <= rx_frame_pkg::PKT_RESET;
                byte_q <= rx_frame_pkg::STATUS0_BYTE;
            end else if (hdr_take) begin
                st0_q <= st0_d;
                st1_q <= st1_d;
                byte_q <= is_result ? rx_frame_pkg::PAYLOAD_FIRST
                    : rx_frame_pkg::STATUS0_BYTE;
            end else if (pkt_done) begin
                pkt_q <= is_result ? rx_frame_pkg::PKT_RESET : 9'(pkt_q + 1'b1);
                byte_q <= rx_frame_pkg::STATUS0_BYTE;
            end else if (wr_en) begin
                byte_q <= 6'(byte_q + 1'b1);
            end
        end
    end

    // visible position, busy and packet quality
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hdr_ready <= 1'b0;
            packet_number_reg_a <= rx_frame_pkg::PKT_RESET;
            packet_number_reg_b <= rx_frame_pkg::STATUS0_BYTE;
            writing <= 1'b0;
            packet_good <= 1'b0;
        end else begin
            hdr_ready <= (state_d == S_IDLE) && !hdr_take;
            packet_number_reg_a <= pkt_q;
            packet_number_reg_b <= byte_q;
            writing <= (state_q != S_IDLE);
            if (hdr_take && !is_result) begin
                packet_good <= !st1_d[rx_frame_pkg::S1_SECOND_PASS_CRC_ERROR]
                    && !st1_d[rx_frame_pkg::S1_SECOND_PASS_CORRECTION_ERROR];
            end
        end
    end

    // host read decode; the packet under write is off limits
    assign rd_in_range = (rd_packet < 9'(rx_frame_pkg::TOTAL_PKTS))
        && (rd_byte <= rx_frame_pkg::LAST_BYTE);
    assign rd_blocked = (state_q != S_IDLE) && (rd_packet == pkt_q);
    assign rd_ok = rd_req && !rd_blocked;

    // host read port, data registered
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_valid <= 1'b0;
            rd_refused <= 1'b0;
            rd_data <= rx_frame_pkg::BYTE_RESET;
        end else begin
            rd_valid <= rd_ok;
            rd_refused <= rd_req && rd_blocked;
            if (rd_ok) begin
                rd_data <= rd_in_range ? frame_mem_q[addr_of(rd_packet, rd_byte)]
                    : rx_frame_pkg::BYTE_RESET;
            end
        end
    end
endmodule

/* rx_frame_store_chk.sv */
// concurrent checks on the frame store ports
`timescale 1ns/100ps
module rx_frame_store_chk (
    // watched ports
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic frame_start,
    input wire logic hdr_valid,
    input wire logic hdr_ready,
    input wire logic second_pass_crc_error,
    input wire logic second_pass_correction_error,
    input wire logic [8:0] packet_number_reg_a,
    input wire logic [5:0] packet_number_reg_b,
    input wire logic writing,
    input wire logic packet_good,
    input wire logic rd_req,
    input wire logic [8:0] rd_packet,
    input wire logic rd_valid,
    input wire logic rd_refused
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // header take, and reads made while busy or idle
    sequence take_s;
        hdr_valid && hdr_ready && !frame_start;
    endsequence
    sequence busy_rd_s;
        rd_req && writing && rd_packet == packet_number_reg_a ##1 writing;
    endsequence
    sequence idle_rd_s;
        rd_req && !writing ##1 !writing;
    endsequence
    one_answer_a: assert property (rd_req |=> rd_valid != rd_refused)
        else $error("read answer missing");
    answer_cause_a: assert property (rd_valid || rd_refused |-> $past(rd_req))
        else $error("answer without read");
    busy_refuse_a: assert property (busy_rd_s |-> rd_refused)
        else $error("busy packet read not refused");
    idle_accept_a: assert property (idle_rd_s |-> rd_valid)
        else $error("idle read refused");
    pos_range_a: assert property (packet_number_reg_a <= 9'h110
        && packet_number_reg_b <= 6'h23) else $error("position out of range");
    hdr_hold_a: assert property (take_s |=> !hdr_ready [*8])
        else $error("header taken mid packet");
    write_start_a: assert property (take_s |-> ##[1:2] writing)
        else $error("write did not start");
    good_flag_a: assert property (hdr_valid && hdr_ready && !frame_start
        && !second_pass_crc_error && !second_pass_correction_error |-> ##[1:3] packet_good)
        else $error("good flag missing");
endmodule

bind rx_frame_store rx_frame_store_chk u_chk (.mclk, .rst_b, .frame_start, .hdr_valid,
    .hdr_ready, .second_pass_crc_error, .second_pass_correction_error, .packet_number_reg_a,
    .packet_number_reg_b, .writing, .packet_good, .rd_req, .rd_packet, .rd_valid, .rd_refused);

/* rx_host_model.sv */
// host microcontroller model on the frame store read port
`timescale 1ns/100ps
module rx_host_model (
    // device side
    input wire logic mclk,
    input wire logic [8:0] packet_number_reg_a,
    input wire logic [5:0] packet_number_reg_b,
    input wire logic rd_valid,
    input wire logic rd_refused,
    input wire logic [7:0] rd_data,
    // read request
    output logic rd_req,
    output logic [8:0] rd_packet,
    output logic [5:0] rd_byte
);
    initial begin
        rd_req = 1'b0;
        rd_packet = 9'h000;
        rd_byte = 6'h00;
    end
    // position is taken once two reads in a row agree, or else from the eighth read
    task automatic get_pos(output logic [8:0] p);
        logic [14:0] a;
        logic [14:0] b;
        b = 15'h7fff;
        for (int i = 0; i < 8; i++) begin
            @(negedge mclk);
            a = {packet_number_reg_a, packet_number_reg_b};
            if (a === b) break;
            b = a;
        end
        p = a[14:6];
    endtask
    // one byte read, request held over the taking edge
    task automatic read(input logic [8:0] p, input logic [5:0] b, output logic [7:0] d,
        output logic [1:0] ans);
        @(negedge mclk);
        rd_req = 1'b1;
        rd_packet = p;
        rd_byte = b;
        @(negedge mclk);
        ans = {rd_valid, rd_refused};
        d = rd_data;
        rd_req = 1'b0;
        rd_packet = ~p; // released lines do not keep the last value
        rd_byte = ~b;
    endtask
endmodule

/* rx_frame_store_tb.sv */
// self-checking bench for the receive frame store
`timescale 1ns/100ps
module rx_frame_store_tb;
    localparam int FDEP = 4;
    logic mclk, rst_b, frame_start, test_parity_correct, hdr_valid, hdr_ready;
    logic pay_valid, pay_ready, writing, packet_good, rd_req, rd_valid, rd_refused;
    logic [7:0] s0, s1, pay_data, rd_data;
    logic [8:0] packet_number_reg_a, rd_packet;
    logic [5:0] packet_number_reg_b, rd_byte;
    int n_fail = 0;
    int checks = 0;
    // design and host
    rx_frame_store #(.FIFO_DEPTH(FDEP)) u_dut (.mclk, .rst_b, .frame_start,
        .test_parity_correct, .hdr_valid, .hdr_ready, .first_pass_crc_error(s0[7]),
        .first_pass_correction_error(s0[6]), .raw_crc_error(s0[5]), .frame_locked(s0[4]),
        .block_locked(s0[3]), .block_code_found(s0[2]), .block_code_index_hi(s0[1]),
        .block_code_index_lo(s0[0]), .traffic_packet_flag(s1[7]),
        .early_interrupt_packet(s1[5]), .second_pass_crc_error(s1[4]),
        .second_pass_correction_error(s1[3]), .frame_number_change(s1[2]),
        .frame_range_hi(s1[1]), .frame_range_lo(s1[0]), .pay_valid, .pay_ready, .pay_data,
        .packet_number_reg_a, .packet_number_reg_b, .writing, .packet_good, .rd_req,
        .rd_packet, .rd_byte, .rd_valid, .rd_refused, .rd_data);
    rx_host_model u_host (.mclk, .packet_number_reg_a, .packet_number_reg_b, .rd_valid,
        .rd_refused, .rd_data, .rd_req, .rd_packet, .rd_byte);
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // stimulus patterns and expected status byte 1
    function automatic logic [7:0] pb(input int p, input int b);
        return 8'(p * 3 + b * 7);
    endfunction
    function automatic logic [7:0] exp1(input int p);
        logic [7:0] h0, h;
        logic par, keep;
        h0 = 8'(p) ^ 8'ha5;
        h = 8'(p) ^ 8'h5a;
        par = p >= rx_frame_pkg::FIRST_PARITY_PKT && p <= rx_frame_pkg::LAST_PARITY_PKT;
        keep = !par || p == 209;
        return {h[7], par & h0[4], h[5], h[4] & keep, h[3] & keep, h[2:0] & {3{h0[4]}}};
    endfunction
    task automatic cmp_val(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_val({1'b0, got}, {1'b0, exp});
    endtask
    // one packet in; optional early fifo fill, optional pause with reads
    task automatic send_pkt(input int p, input logic fill, input int stop);
        int n;
        logic th, tp, paused;
        logic [7:0] d;
        logic [1:0] a;
        n = 0;
        paused = 1'b0;
        s0 = 8'(p) ^ 8'ha5;
        s1 = 8'(p) ^ 8'h5a;
        test_parity_correct = (p == 209);
        hdr_valid = !fill;
        pay_valid = 1'b1;
        pay_data = pb(p, 2);
        while (n < 34 || hdr_valid) begin
            th = hdr_valid && hdr_ready;
            tp = pay_valid && pay_ready;
            @(negedge mclk);
            n += int'(tp);
            if (th) begin
                hdr_valid = 1'b0;
            end else if (fill && n < 34 && !pay_ready && !hdr_valid && !paused) begin
                hdr_valid = 1'b1;
                paused = 1'b1;
                cmp_val(9'(n), 9'(FDEP));
            end
            pay_valid = n < 34 && (paused || n != stop);
            pay_data = pb(p, n + 2);
            if (n == stop && !paused) begin
                paused = 1'b1;
                cmp_val({8'h00, writing}, 9'h001);
                u_host.read(9'(p), 6'h00, d, a);
                cmp_val({7'h00, a}, 9'h001);
                u_host.read(9'(p - 1), 6'h02, d, a);
                cmp_val({7'h00, a}, 9'h002);
                cmp_byte(d, pb(p - 1, 2));
            end
        end
        while (!hdr_ready) @(negedge mclk);
        repeat (2) @(negedge mclk);
    endtask
    // read a whole stored packet back between packets
    task automatic check_pkt(input int p);
        logic [7:0] d;
        logic [1:0] a;
        logic [8:0] q;
        u_host.get_pos(q);
        cmp_val(q, 9'((p + 1) % 273));
        cmp_val({3'h0, packet_number_reg_b}, 9'h000);
        for (int b = 0; b < 36; b++) begin
            if (p == 272 && b < 2) continue;
            u_host.read(9'(p), 6'(b), d, a);
            cmp_val({7'h00, a}, 9'h002);
            cmp_byte(d, b == 0 ? s0 : b == 1 ? exp1(p) : pb(p, b));
        end
        if (p < 190) cmp_val({8'h00, packet_good}, {8'h00, ~(s1[4] | s1[3])});
        // an address past the last packet answers with zero
        if (p == 272) begin
            u_host.read(9'h111, 6'h00, d, a);
            cmp_byte(d, 8'h00);
        end
        $display("packet %0d checked", p);
    endtask
    // header taken, then a frame restart before any payload arrives
    task automatic abort_pkt();
        hdr_valid = 1'b1;
        @(negedge mclk);
        hdr_valid = 1'b0;
        repeat (9) @(negedge mclk);
        cmp_val({8'h00, writing}, 9'h001);
        frame_start = 1'b1;
        @(negedge mclk);
        frame_start = 1'b0;
        repeat (2) @(negedge mclk);
        cmp_val({7'h00, writing, hdr_ready}, 9'h001);
        cmp_val(packet_number_reg_a, 9'h000);
        $display("abort checked");
    endtask
    task automatic finish_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // reset, then one full frame of 273 packets
    initial begin
        {rst_b, frame_start, test_parity_correct, hdr_valid, pay_valid} = 5'h00;
        {s0, s1, pay_data} = 24'h000000;
        repeat (5) @(negedge mclk);
        rst_b = 1'b1;
        repeat (2) @(negedge mclk);
        frame_start = 1'b1;
        @(negedge mclk);
        frame_start = 1'b0;
        for (int p = 0; p < 273; p++) begin
            send_pkt(p, p == 0, p == 9 ? 10 : 99);
            if (p < 8 || p == 189 || p == 190 || p == 208 || p == 209 || p == 272) check_pkt(p);
        end
        abort_pkt();
        finish_test();
    end
    // watchdog
    initial begin
        repeat (40000) @(posedge mclk);
        n_fail++;
        $display("Error %0t: timeout", $time);
        finish_test();
    end
endmodule
